// ===== shared/slr_defines.vh
`ifndef SLR_DEFINES_VH
`define SLR_DEFINES_VH
// ----------------------------------------
// timing
// ----------------------------------------
`define SLR_CLK_HZ 10000000
`define SLR_MS_TIME_US 1000
`define SLR_MS_CYCLES ((`SLR_CLK_HZ / 1000000) * `SLR_MS_TIME_US)
`define SLR_QUICK_HALF_MS 125
`define SLR_SLOW_HALF_MS 500
`define SLR_MS_PER_DAY 32'h05265C00
// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define SLR_OFS_TIME_MS 8'h00
`define SLR_OFS_TIME_DAYS 8'h04
`define SLR_OFS_READY_REQ 8'h08
`define SLR_OFS_SAFE_LINK_REQ 8'h0C
`define SLR_OFS_BF_REQ 8'h10
`define SLR_OFS_BUS_CFG 8'h14
`define SLR_OFS_IRQ_STATUS 8'h18
`define SLR_OFS_IRQ_MASK 8'h1C
`define SLR_OFS_SNAP_MS 8'h20
`define SLR_OFS_SNAP_DAYS 8'h24
`define SLR_OFS_LAMPS 8'h28
// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define SLR_RDY_POWERUP 0
`define SLR_RDY_OK 1
`define SLR_RDY_COMMISSION 2
`define SLR_RDY_FAULT 3
`define SLR_RDY_FW_ACTIVE 4
`define SLR_RDY_WAIT_CYCLE 5
`define SLR_RDY_WRONG_CARD 6
`define SLR_BF_DATA 0
`define SLR_BF_UNUSED 1
`define SLR_BF_NO_DATA 2
`define SLR_BF_NO_CONN 3
`define SLR_BF_FW_FAIL 4
`define SLR_BF_FW_ACTIVE 5
`define SLR_SAFE_POS 0
`define SLR_LINK_POS 4
`define SLR_CFG_RS485 0
`define SLR_CFG_MODBUS 1
`define SLR_CFG_MON_POS 8
`define SLR_IRQ_SNAP 0
`define SLR_IRQ_DAY 1
`define SLR_READY_REQ_RST 7'h01
`define SLR_BUS_CFG_RST 16'h0101
`endif

// ===== hw/slr_tick_div.v
`default_nettype none
// ----------------------------------------
// enabled divider, one-cycle tick every N enables
// ----------------------------------------
module slr_tick_div #(
  parameter integer N = 10
) (
  // clock and reset
  input wire clk,
  input wire resetn,
  // count enable and tick
  input wire en,
  output reg tick
);
  localparam integer W = (N > 1) ? $clog2(N) : 1;
  localparam integer LAST_I = N - 1;
  localparam integer ONE_I = 1;
  localparam [W-1:0] LAST = LAST_I[W-1:0];
  localparam [W-1:0] ONE = ONE_I[W-1:0];
  reg [W-1:0] cnt_q;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= {W{1'b0}};
      tick <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (en) begin
        if (cnt_q == LAST) begin
          cnt_q <= {W{1'b0}};
          tick <= 1'b1;
        end else begin
          cnt_q <= cnt_q + ONE;
        end
      end
    end
  end
endmodule // slr_tick_div
`default_nettype wire

// ===== hw/slr_sync3.v
`default_nettype none
// ----------------------------------------
// three-stage pin synchroniser, takes a change when stages 2 and 3 agree
// ----------------------------------------
module slr_sync3 (
  // clock and reset
  input wire clk,
  input wire resetn,
  // pin and clean level
  input wire pin,
  output reg level
);
  reg s1_q;
  reg s2_q;
  reg s3_q;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      level <= 1'b0;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        level <= s3_q;
      end
    end
  end
endmodule // slr_sync3
`default_nettype wire

// ===== hw/slr_top.v
// The address-and-strobe port and the address map are this design's own decisions.
`include "slr_defines.vh"
`default_nettype none
module slr_top #(
  parameter integer MS_CYCLES = `SLR_MS_CYCLES,
  parameter integer QUICK_HALF_MS = `SLR_QUICK_HALF_MS,
  parameter integer SLOW_HALF_MS = `SLR_SLOW_HALF_MS
) (
  // clock and reset
  input wire clk,
  input wire resetn,
  // register port
  input wire [7:0] addr,
  input wire [31:0] wdata,
  input wire wr,
  input wire rd,
  output reg [31:0] rdata,
  // alarm or fault message raised (pin)
  input wire msg_raise_pin,
  // lamps
  output reg ready_lamp_green,
  output reg ready_lamp_red,
  output reg safety_lamp,
  output reg network_link_lamp,
  output reg bus_fault_lamp_green,
  output reg bus_fault_lamp_red,
  // interrupt
  output reg irq
);
  // ----------------------------------------
  // pattern codes
  // ----------------------------------------
  localparam [2:0] P_OFF = 3'h0;
  localparam [2:0] P_ON = 3'h1;
  localparam [2:0] P_SLOW = 3'h2;
  localparam [2:0] P_QUICK = 3'h3;
  localparam [2:0] P_VAR = 3'h4;
  localparam [2:0] P_QUICK_INV = 3'h5;

  // ----------------------------------------
  // time base and flash waves
  // ----------------------------------------
  wire ms_tick;
  wire quick_tick;
  wire slow_tick;
  reg quick_wave_q;
  reg slow_wave_q;
  reg var_sel_q;
  wire var_wave;

  slr_tick_div #(.N(MS_CYCLES)) u_ms_div (
    .clk(clk),
    .resetn(resetn),
    .en(1'b1),
    .tick(ms_tick)
  );
  slr_tick_div #(.N(QUICK_HALF_MS)) u_quick_div (
    .clk(clk),
    .resetn(resetn),
    .en(ms_tick),
    .tick(quick_tick)
  );
  slr_tick_div #(.N(SLOW_HALF_MS)) u_slow_div (
    .clk(clk),
    .resetn(resetn),
    .en(ms_tick),
    .tick(slow_tick)
  );

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      quick_wave_q <= 1'b0;
      slow_wave_q <= 1'b0;
      var_sel_q <= 1'b0;
    end else begin
      if (quick_tick) begin
        quick_wave_q <= ~quick_wave_q;
      end
      if (slow_tick) begin
        slow_wave_q <= ~slow_wave_q;
        if (slow_wave_q) begin
          var_sel_q <= ~var_sel_q;
        end
      end
    end
  end
  // variable rate: alternates slow and quick periods
  assign var_wave = var_sel_q ? quick_wave_q : slow_wave_q;

  function wave_of;
    input [2:0] p;
    input qw;
    input sw;
    input vw;
    begin
      case (p)
        P_ON: wave_of = 1'b1;
        P_SLOW: wave_of = sw;
        P_QUICK: wave_of = qw;
        P_QUICK_INV: wave_of = ~qw;
        P_VAR: wave_of = vw;
        default: wave_of = 1'b0;
      endcase
    end
  endfunction

  // ----------------------------------------
  // message pin
  // ----------------------------------------
  wire msg_level;
  reg msg_level_q;
  wire msg_event;
  slr_sync3 u_msg_sync (
    .clk(clk),
    .resetn(resetn),
    .pin(msg_raise_pin),
    .level(msg_level)
  );
  assign msg_event = msg_level & ~msg_level_q;

  // ----------------------------------------
  // powered-time counter
  // ----------------------------------------
  reg [31:0] time_ms_q;
  reg [31:0] time_days_q;
  reg [31:0] snap_ms_q;
  reg [31:0] snap_days_q;
  wire day_wrap;
  assign day_wrap = ms_tick & (time_ms_q == (`SLR_MS_PER_DAY - 32'h00000001));

  // no write path exists to the counter words
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      time_ms_q <= 32'h00000000;
      time_days_q <= 32'h00000000;
      snap_ms_q <= 32'h00000000;
      snap_days_q <= 32'h00000000;
      msg_level_q <= 1'b0;
    end else begin
      msg_level_q <= msg_level;
      if (day_wrap) begin
        time_ms_q <= 32'h00000000;
        time_days_q <= time_days_q + 32'h00000001;
      end else if (ms_tick) begin
        time_ms_q <= time_ms_q + 32'h00000001;
      end
      if (msg_event) begin
        snap_ms_q <= time_ms_q;
        snap_days_q <= time_days_q;
      end
    end
  end

  // ----------------------------------------
  // control registers and interrupts
  // ----------------------------------------
  reg [6:0] ready_req_q;
  reg [2:0] safe_req_q;
  reg [2:0] link_req_q;
  reg [5:0] bf_req_q;
  reg [15:0] bus_cfg_q;
  reg [1:0] irq_status_q;
  reg [1:0] irq_mask_q;
  wire [1:0] irq_set;
  wire [1:0] irq_clr;
  assign irq_set = {day_wrap, msg_event};
  assign irq_clr = (wr && addr == `SLR_OFS_IRQ_STATUS) ? wdata[1:0] : 2'h0;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ready_req_q <= `SLR_READY_REQ_RST;
      safe_req_q <= 3'h0;
      link_req_q <= 3'h0;
      bf_req_q <= 6'h00;
      bus_cfg_q <= `SLR_BUS_CFG_RST;
      irq_status_q <= 2'h0;
      irq_mask_q <= 2'h0;
    end else begin
      if (wr) begin
        case (addr)
          `SLR_OFS_READY_REQ: ready_req_q <= wdata[6:0];
          `SLR_OFS_SAFE_LINK_REQ: begin
            safe_req_q <= wdata[`SLR_SAFE_POS+2:`SLR_SAFE_POS];
            link_req_q <= wdata[`SLR_LINK_POS+2:`SLR_LINK_POS];
          end
          `SLR_OFS_BF_REQ: bf_req_q <= wdata[5:0];
          `SLR_OFS_BUS_CFG: bus_cfg_q <= wdata[15:0];
          `SLR_OFS_IRQ_MASK: irq_mask_q <= wdata[1:0];
          default: ;
        endcase
      end
      // set wins over a simultaneous clear
      irq_status_q <= (irq_status_q & ~irq_clr) | irq_set;
    end
  end

  // ----------------------------------------
  // lamp state selection
  // ----------------------------------------
  reg [2:0] rdy_g_p;
  reg [2:0] rdy_r_p;
  reg [2:0] safe_p;
  reg [2:0] link_p;
  reg [2:0] bf_g_p;
  reg [2:0] bf_r_p;
  wire rs485;
  wire bf_dark;
  assign rs485 = bus_cfg_q[`SLR_CFG_RS485];
  assign bf_dark = bus_cfg_q[`SLR_CFG_MODBUS] &
                   (bus_cfg_q[`SLR_CFG_MON_POS+7:`SLR_CFG_MON_POS] == 8'h00);

  always @* begin
    rdy_g_p = P_OFF;
    rdy_r_p = P_OFF;
    // update and fault states outrank normal ones
    if (ready_req_q[`SLR_RDY_FW_ACTIVE]) begin
      rdy_r_p = P_VAR;
    end else if (ready_req_q[`SLR_RDY_WAIT_CYCLE]) begin
      rdy_r_p = P_SLOW;
    end else if (ready_req_q[`SLR_RDY_WRONG_CARD]) begin
      rdy_g_p = P_QUICK_INV;
      rdy_r_p = P_QUICK_INV;
    end else if (ready_req_q[`SLR_RDY_FAULT]) begin
      rdy_r_p = P_QUICK;
    end else if (ready_req_q[`SLR_RDY_COMMISSION]) begin
      rdy_g_p = P_SLOW;
    end else if (ready_req_q[`SLR_RDY_OK]) begin
      rdy_g_p = P_ON;
    end else begin
      rdy_g_p = P_ON;
      rdy_r_p = P_ON;
    end
  end

  always @* begin
    safe_p = P_OFF;
    if (safe_req_q[2]) begin
      safe_p = P_QUICK;
    end else if (safe_req_q[1]) begin
      safe_p = P_ON;
    end else if (safe_req_q[0]) begin
      safe_p = P_SLOW;
    end
    link_p = P_OFF;
    if (link_req_q[1]) begin
      link_p = P_SLOW;
    end else if (link_req_q[0]) begin
      link_p = P_ON;
    end
  end

  always @* begin
    bf_g_p = P_OFF;
    bf_r_p = P_OFF;
    if (bf_dark) begin
      bf_r_p = P_OFF;
    end else if (bf_req_q[`SLR_BF_FW_ACTIVE]) begin
      bf_r_p = P_VAR;
    end else if (bf_req_q[`SLR_BF_FW_FAIL]) begin
      bf_r_p = P_ON;
    end else if (ready_req_q[`SLR_RDY_WAIT_CYCLE]) begin
      bf_r_p = P_SLOW;
    end else if (ready_req_q[`SLR_RDY_WRONG_CARD]) begin
      bf_r_p = P_QUICK;
    end else if (bf_req_q[`SLR_BF_NO_CONN]) begin
      bf_r_p = P_QUICK;
    end else if (bf_req_q[`SLR_BF_NO_DATA]) begin
      bf_r_p = P_SLOW;
    end else if (bf_req_q[`SLR_BF_UNUSED] && !rs485) begin
      bf_r_p = P_OFF;
    end else if (bf_req_q[`SLR_BF_DATA]) begin
      bf_g_p = P_ON;
    end
  end

  // ----------------------------------------
  // registered outputs
  // ----------------------------------------
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ready_lamp_green <= 1'b0;
      ready_lamp_red <= 1'b0;
      safety_lamp <= 1'b0;
      network_link_lamp <= 1'b0;
      bus_fault_lamp_green <= 1'b0;
      bus_fault_lamp_red <= 1'b0;
      irq <= 1'b0;
    end else begin
      ready_lamp_green <= wave_of(rdy_g_p, quick_wave_q, slow_wave_q, var_wave);
      ready_lamp_red <= wave_of(rdy_r_p, quick_wave_q, slow_wave_q, var_wave);
      safety_lamp <= wave_of(safe_p, quick_wave_q, slow_wave_q, var_wave);
      network_link_lamp <= wave_of(link_p, quick_wave_q, slow_wave_q, var_wave);
      bus_fault_lamp_green <= wave_of(bf_g_p, quick_wave_q, slow_wave_q, var_wave);
      bus_fault_lamp_red <= wave_of(bf_r_p, quick_wave_q, slow_wave_q, var_wave);
      irq <= |((irq_status_q | irq_set) & irq_mask_q);
    end
  end

  // ----------------------------------------
  // read path
  // ----------------------------------------
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata <= 32'h00000000;
    end else if (rd) begin
      case (addr)
        `SLR_OFS_TIME_MS: rdata <= time_ms_q;
        `SLR_OFS_TIME_DAYS: rdata <= time_days_q;
        `SLR_OFS_READY_REQ: rdata <= {25'h0, ready_req_q};
        `SLR_OFS_SAFE_LINK_REQ: rdata <= {25'h0, link_req_q, 1'b0, safe_req_q};
        `SLR_OFS_BF_REQ: rdata <= {26'h0, bf_req_q};
        `SLR_OFS_BUS_CFG: rdata <= {16'h0, bus_cfg_q};
        `SLR_OFS_IRQ_STATUS: rdata <= {30'h0, irq_status_q};
        `SLR_OFS_IRQ_MASK: rdata <= {30'h0, irq_mask_q};
        `SLR_OFS_SNAP_MS: rdata <= snap_ms_q;
        `SLR_OFS_SNAP_DAYS: rdata <= snap_days_q;
        `SLR_OFS_LAMPS: rdata <= {26'h0, bus_fault_lamp_red, bus_fault_lamp_green,
                                  network_link_lamp, safety_lamp,
                                  ready_lamp_red, ready_lamp_green};
        default: rdata <= 32'h00000000;
      endcase
    end else begin
      rdata <= 32'h00000000;
    end
  end
endmodule // slr_top
`default_nettype wire

// ===== hw/slr_top_unused_placeholder_none.v
`default_nettype none
`default_nettype wire

// ===== verif/slr_top_asserts.sv
`default_nettype none
module slr_chk (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] rdata,
  // lamps
  input wire logic ready_lamp_green,
  input wire logic ready_lamp_red,
  input wire logic bus_fault_lamp_green,
  input wire logic bus_fault_lamp_red
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------
  // shadows of written requests, last day word read, and cycles since a write
  // ----------
  logic [6:0] rdy_q;
  logic [15:0] cfg_q;
  logic [1:0] fw_q;
  logic [1:0] qt_q;
  logic [31:0] day_q;
  logic rd_q;
  logic [7:0] ad_q;
  logic s;
  logic dk;
  assign s = qt_q == 2'h3;
  assign dk = cfg_q[1] && cfg_q[15:8] == 8'h00;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdy_q <= 7'h01;
      cfg_q <= 16'h0101;
      fw_q <= 2'h0;
      qt_q <= 2'h0;
      day_q <= 32'h0;
      rd_q <= 1'b0;
      ad_q <= 8'h00;
    end else begin
      rd_q <= rd;
      ad_q <= addr;
      qt_q <= wr ? 2'h0 : (qt_q == 2'h3 ? qt_q : qt_q + 2'h1);
      if (wr && addr == 8'h08) rdy_q <= wdata[6:0];
      if (wr && addr == 8'h10) fw_q <= wdata[5:4];
      if (wr && addr == 8'h14) cfg_q <= wdata[15:0];
      if (rd_q && ad_q == 8'h04) day_q <= rdata;
    end
  end
  // ----------
  // checks
  // ----------
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!resetn);
  ms_bound_a: assert property (
    rd && addr == 8'h00 |=> rdata < 32'h05265C00) else $error("ms word reached one day");
  days_step_a: assert property (
    rd_q && ad_q == 8'h04 |-> rdata == day_q || rdata == day_q + 32'h1)
    else $error("day word jumped");
  powerup_lamp_a: assert property (
    $rose(resetn) |-> ##[1:2] (ready_lamp_green && ready_lamp_red))
    else $error("no power-up pattern");
  dark_bf_a: assert property (
    s && dk |-> !bus_fault_lamp_green && !bus_fault_lamp_red) else $error("bus lamp not dark");
  fault_prio_a: assert property (
    s && rdy_q[6:3] == 4'h1 |-> !ready_lamp_green) else $error("fault shows green");
  fw_prio_a: assert property (
    s && rdy_q[4] |-> !ready_lamp_green) else $error("update shows green");
  ok_steady_a: assert property (
    s && rdy_q[6:1] == 6'h01 |-> ready_lamp_green && !ready_lamp_red)
    else $error("ok not steady green");
  wait_phase_a: assert property (
    s && !dk && fw_q == 2'h0 && rdy_q[5:4] == 2'h2 |-> ready_lamp_red == bus_fault_lamp_red)
    else $error("wait lamps out of step");
endmodule // slr_chk
bind slr_top slr_chk u_chk (
  .clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .ready_lamp_green(ready_lamp_green), .ready_lamp_red(ready_lamp_red),
  .bus_fault_lamp_green(bus_fault_lamp_green), .bus_fault_lamp_red(bus_fault_lamp_red)
);
`default_nettype wire

// ===== verif/slr_lamp_watch.sv
`default_nettype none
module slr_lamp_watch (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // window restart and lamps
  input wire logic clr,
  input wire logic [5:0] lamp,
  // toggles per lamp since restart
  output logic [47:0] tog
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [5:0] prev_q;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prev_q <= 6'h00;
      tog <= 48'h0;
    end else begin
      prev_q <= lamp;
      for (int i = 0; i < 6; i++) begin
        if (clr) tog[8*i +: 8] <= 8'h00;
        else if (lamp[i] != prev_q[i]) tog[8*i +: 8] <= tog[8*i +: 8] + 8'h01;
      end
    end
  end
endmodule // slr_lamp_watch
`default_nettype wire

// ===== verif/slr_top_tb_top.sv
`default_nettype none
module slr_top_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic pin = 1'b0;
  logic clr = 1'b0;
  logic [31:0] rdata;
  logic [5:0] lamps;
  logic [47:0] tog;
  logic irq;
  int fail_count = 0;
  int n_tests = 0;
  int cyc = 0;
  logic [31:0] v;
  logic [31:0] m;
  logic [23:0] rdy_t [7] = '{24'h11, 24'h01, 24'h02, 24'h30, 24'h40, 24'h200020, 24'h300033};
  logic [23:0] bf_t [6] = '{24'h010001, 24'h1, 24'h200001, 24'h300001, 24'h100001, 24'h400001};
  logic [7:0] ra [7] = '{8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h04, 8'h2C};
  logic [31:0] rv [7] = '{32'h1, 32'h0, 32'h0, 32'h101, 32'h0, 32'h0, 32'h0};
  always #50 clk = ~clk;
  slr_top #(.MS_CYCLES(4), .QUICK_HALF_MS(2), .SLOW_HALF_MS(3)) DUT (
    .clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .msg_raise_pin(pin), .ready_lamp_green(lamps[0]), .ready_lamp_red(lamps[1]),
    .safety_lamp(lamps[2]), .network_link_lamp(lamps[3]), .bus_fault_lamp_green(lamps[4]),
    .bus_fault_lamp_red(lamps[5]), .irq(irq)
  );
  slr_lamp_watch u_watch (.clk(clk), .resetn(resetn), .clr(clr), .lamp(lamps), .tog(tog));
  // ----------
  // tasks
  // ----------
  task automatic final_report;
    if (fail_count == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  // lamp codes per nibble: 0 off, 1 on, 2 slow, 3 quick, 4 variable, F any
  task automatic pat(input logic [7:0] a, input logic [31:0] d, input logic [23:0] e);
    logic [3:0] p;
    wr_reg(a, d);
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (96) @(posedge clk);
    #1;
    for (int i = 0; i < 6; i++) begin
      p = e[4*i +: 4];
      if (p == 4) chk(32'(tog[8*i +: 8] != 0), 32'h1);
      else if (p < 4) chk(32'(tog[8*i +: 8]), p == 2 ? 32'd8 : (p == 3 ? 32'd12 : 32'd0));
      if (p < 2) chk(32'(lamps[i]), 32'(p));
    end
  endtask
  task automatic pulse;
    @(posedge clk);
    pin <= 1'b1;
    repeat (4) @(posedge clk);
    pin <= 1'b0;
    repeat (12) @(posedge clk);
    #1;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 10000) begin
      fail_count++;
      final_report();
    end
  end
  // ----------
  // sequence
  // ----------
  initial begin
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      rd_reg(ra[i], v);
      chk(v, rv[i]);
    end
    rd_reg(8'h28, v);
    chk(v, 32'h3);
    wr_reg(8'h00, 32'hFFFFFFFF);
    wr_reg(8'h04, 32'hFFFFFFFF);
    rd_reg(8'h04, v);
    chk(v, 32'h0);
    rd_reg(8'h00, m);
    chk(32'(m < 32'd100), 32'h1);
    repeat (40) @(posedge clk);
    rd_reg(8'h00, v);
    chk(32'(v - m >= 10 && v - m <= 11), 32'h1);
    for (int k = 0; k < 7; k++) pat(8'h08, 32'h1 << k, rdy_t[k]);
    pat(8'h08, 32'h7F, 24'h200040);
    pat(8'h08, 32'h0A, 24'h30);
    wr_reg(8'h08, 32'h02);
    pat(8'h0C, 32'h01, 24'h0201);
    pat(8'h0C, 32'h02, 24'h0101);
    pat(8'h0C, 32'h07, 24'h0301);
    pat(8'h0C, 32'h10, 24'h1001);
    pat(8'h0C, 32'h20, 24'h2001);
    wr_reg(8'h0C, 32'h0);
    for (int c = 0; c < 2; c++) begin
      wr_reg(8'h14, 32'h101 - c);
      for (int k = 0; k < 6; k++) begin
        pat(8'h10, 32'h1 << k, bf_t[k]);
      end
    end
    pat(8'h10, 32'h3F, 24'h400001);
    wr_reg(8'h10, 32'h0);
    pat(8'h08, 32'h20, 24'h200020);
    pat(8'h08, 32'h40, 24'h300033);
    wr_reg(8'h08, 32'h02);
    wr_reg(8'h10, 32'h01);
    pat(8'h14, 32'h0003, 24'h01);
    pat(8'h14, 32'h0103, 24'h010001);
    wr_reg(8'h1C, 32'h1);
    pulse();
    chk(32'(irq), 32'h1);
    rd_reg(8'h18, v);
    chk(v, 32'h1);
    rd_reg(8'h20, m);
    rd_reg(8'h00, v);
    chk(32'(m > 0 && v - m <= 8), 32'h1);
    rd_reg(8'h24, v);
    chk(v, 32'h0);
    wr_reg(8'h18, 32'h1);
    repeat (3) @(posedge clk);
    #1;
    chk(32'(irq), 32'h0);
    wr_reg(8'h1C, 32'h0);
    pulse();
    chk(32'(irq), 32'h0);
    rd_reg(8'h18, v);
    chk(v, 32'h1);
    final_report();
  end
endmodule // slr_top_tb_top
`default_nettype wire
